/* File: msg_handler_pkg.sv */
package msg_handler_pkg;
   // Clock and line timing
   localparam int CLOCK_HZ = 20_000_000;
   localparam int CLK_NS = 50;
   localparam int LINE_BAUD = 9600;
   // Longest whole number of clocks inside one bit period
   localparam int BIT_CYCLES = CLOCK_HZ / LINE_BAUD;
   localparam int IDLE_BITS = 24;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYCLES_DEF = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLINK_MS = 250;
   // Addressing
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MAX = 8'h20;
   // Function codes and error marking
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_LOOP = 8'h08;
   localparam logic [7:0] FC_WRITE = 8'h10;
   localparam logic [7:0] FC_ERR_BIT = 8'h80;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_REG = 8'h02;
   localparam logic [7:0] ERR_COUNT = 8'h03;
   // Sizes
   localparam int MAX_WORDS = 16;
   localparam int REG_WORDS = 16;
   localparam int BUF_BYTES = 48;
   localparam int FIFO_DEPTH = 16;
   localparam int MIN_FRAME = 4;
   localparam int N_TERMINALS = 7;
   localparam int FSEL_W = 6;
   // Check word: generator 1 1000 0000 0000 0101, bit-reversed for LSB-first
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
   // Link registers that steer the drive
   localparam logic [3:0] REG_RUN = 4'h1;
   localparam logic [3:0] REG_FREQ = 4'h2;
   // Terminal function codes
   localparam logic [5:0] FUNC_RAMP1 = 6'h0b;
   localparam logic [5:0] FUNC_COMM_SEL = 6'h12;
   localparam logic [5:0] FUNC_PREALARM = 6'h1a;
   localparam logic [5:0] FUNC_RAMP2 = 6'h1b;
   // Source selections meaning "from the link"
   localparam logic [1:0] RUN_SRC_COMM = 2'h2;
   localparam logic [3:0] FREQ_SRC_COMM = 4'h6;

   // One byte of the check word, least significant bit first
   function automatic logic [15:0] crc16_step(input logic [15:0] crc,
                                              input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
      return c;
   endfunction : crc16_step
endpackage : msg_handler_pkg

/* File: byte_fifo.sv */
`timescale 1ns/100ps
// Small first-in first-out store with valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [AW-1:0] wr_ptr; // Next slot to fill
   logic [AW-1:0] rd_ptr; // Next slot to drain
   logic [AW:0] count; // Words held
   logic push; // Word taken in
   logic pop; // Word handed out

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Read data comes from the head register of the store
   assign out_data = mem[rd_ptr];

   // Storage writes need no reset
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers wrap naturally because depth is a power of two
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

   a_fifo_no_overflow : assert property (@(posedge clock) disable iff (!resetn)
      count <= (AW+1)'(DEPTH))
      else $error("fifo holds more than its depth");
endmodule : byte_fifo

/* File: serial_slave_message_handler.sv */
`timescale 1ns/100ps
// Function
// R1: Terminal function 18 high selects link commands
// R2: Terminal low uses run and frequency selections
// R3: Terminal function 26 blinks overheat prealarm
// R4: Functions 11 and 27 pick ramp pair
// R5: Frame: address, function, data, two check
// R6: Reply after 24 bits plus wait time
// R7: Master waits 24 bits plus 10 ms
// R8: Frames are raw binary bytes only
// R9: Accept own station number or broadcast
// R10: Address 00 is broadcast to all
// R11: Broadcast writes only run and frequency; the code writes any addressed register in range
// R12: Never reply to a broadcast
// R13: Code 03 reads up to 16 words
// R14: Code 08 echoes the request unchanged
// R15: Code 10 writes up to 16 words
// R16: Other codes flag error, error reply
// R17: Reply echoes code, top bit on error
// R18: Check word is generator 18005 remainder
// R19: Check starts all ones, low byte first
// R20: Everything moves as whole bytes
// R21: Error reply: address, code, error, check
// R22: Idle ends frame; bad check drops it
module serial_slave_message_handler
   import msg_handler_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Received bytes from the line receiver
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   // Reply bytes to the line transmitter
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   // Link settings
   input wire logic [7:0] link_station_number,
   input wire logic [7:0] reply_wait_time,
   input wire logic [1:0] run_source_select,
   input wire logic [3:0] freq_ref_source_select,
   // Input terminals and their function assignments
   input wire logic [N_TERMINALS-1:0] input_terminals,
   input wire logic [N_TERMINALS*FSEL_W-1:0] input_terminal_function_selects,
   // Locally selected command sources
   input wire logic [15:0] local_run_cmd,
   input wire logic [15:0] local_freq_ref,
   // Drive commands and status
   output logic [15:0] run_command,
   output logic [15:0] freq_reference,
   output logic overheat_prealarm,
   output logic [1:0] ramp_time_select,
   output logic comm_error,
   output logic frame_dropped
);
   typedef enum logic [2:0] {
      st_recv, st_exec, st_wait, st_send, st_crc_lo, st_crc_hi
   } state_t;

   // True when any terminal assigned this function is high
   function automatic logic terminal_on(
      input logic [FSEL_W-1:0] code,
      input logic [N_TERMINALS-1:0] level,
      input logic [N_TERMINALS*FSEL_W-1:0] sel);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERMINALS; i++)
      begin
         if (sel[i*FSEL_W +: FSEL_W] == code && level[i])
            hit = 1'b1;
      end
      return hit;
   endfunction : terminal_on

   state_t state; // Handler phase
   logic [7:0] rx_buf [BUF_BYTES]; // Captured request bytes
   logic [5:0] rx_len; // Bytes captured
   logic overrun; // Request longer than the buffer
   logic [15:0] rx_crc; // Running check over the request
   logic [11:0] bit_cnt; // Bit period divider
   logic bit_tick; // One pulse per bit period
   logic [4:0] idle_bits; // Quiet bit periods since last byte
   logic frame_end; // Line quiet long enough
   logic [15:0] ms_cnt; // Millisecond divider
   logic ms_tick; // One pulse per millisecond
   logic [7:0] wait_ms; // Milliseconds waited before replying
   logic [7:0] blink_ms; // Blink half-period count
   logic blink_phase; // Display blink phase
   logic [15:0] regs [REG_WORDS]; // Link word registers
   logic [7:0] err_code; // Error of the current reply
   logic [5:0] reply_len; // Reply bytes ahead of the check word
   logic [5:0] tx_idx; // Reply byte being queued
   logic [15:0] tx_crc; // Running check over the reply
   logic [7:0] reply_byte; // Byte to queue next
   logic fifo_in_valid; // Byte offered to the reply queue
   logic [7:0] fifo_in_data; // That byte
   logic fifo_in_ready; // Queue has room
   // Request decode, meaningful during the execute phase
   logic [15:0] req_start; // First register number
   logic [15:0] req_count; // Number of words
   logic [16:0] req_end; // One past last register
   logic frame_ok; // Check and length fine
   logic addr_hit; // Own station or broadcast
   logic is_bcast; // Broadcast address
   logic [7:0] next_err; // Error found in the request
   logic [5:0] next_reply_len; // Reply length for the request
   logic wr_go; // Commit a write now

   // Receiver accepts only while collecting a request
   assign rx_ready = (state == st_recv);

   // Bit-period enable, restarted by every byte so idle is measured exactly
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         bit_cnt <= '0;
      else if ((rx_valid && rx_ready) || bit_tick)
         bit_cnt <= '0;
      else
         bit_cnt <= bit_cnt + 12'h001;
   end
   assign bit_tick = (bit_cnt == 12'(BIT_CYCLES - 1));

   // Quiet time on the line closes a frame, no start or end characters
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         idle_bits <= '0;
      else if (rx_valid && rx_ready)
         idle_bits <= '0;
      else if (bit_tick && idle_bits != 5'(IDLE_BITS))
         idle_bits <= idle_bits + 5'h01;
   end
   assign frame_end = (state == st_recv) && bit_tick && (rx_len != '0)
      && (idle_bits == 5'(IDLE_BITS - 1)); // see R22

   // Byte capture; extra bytes mark the frame as overrun
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_len <= '0;
         overrun <= 1'b0;
         rx_crc <= CRC_INIT;
      end
      else if (state == st_exec)
      begin
         rx_len <= '0;
         overrun <= 1'b0;
         rx_crc <= CRC_INIT; // see R19
      end
      else if (rx_valid && rx_ready)
      begin
         // Whole binary bytes, check folded in as they arrive
         rx_crc <= crc16_step(rx_crc, rx_data); // see R8 see R18 see R20
         if (rx_len == 6'(BUF_BYTES))
            overrun <= 1'b1;
         else
            rx_len <= rx_len + 6'h01;
      end
   end

   // Buffer contents need no reset; the length says what is valid
   always_ff @(posedge clock)
   begin
      if (rx_valid && rx_ready && rx_len != 6'(BUF_BYTES))
         rx_buf[rx_len] <= rx_data; // see R5
   end

   // Request decode: byte 0 address, 1 function, then data fields
   always_comb
   begin
      req_start = {rx_buf[2], rx_buf[3]};
      req_count = {rx_buf[4], rx_buf[5]};
      req_end = {1'b0, req_start} + {1'b0, req_count};
      // Check over the whole frame including its check bytes leaves zero
      frame_ok = (rx_crc == 16'h0000) && !overrun
         && (rx_len >= 6'(MIN_FRAME)); // see R18 see R22
      is_bcast = (rx_buf[0] == ADDR_BCAST); // see R10
      addr_hit = is_bcast || (rx_buf[0] == link_station_number
         && link_station_number <= ADDR_MAX); // see R9
      next_err = ERR_NONE;
      next_reply_len = rx_len - 6'h02;
      unique case (rx_buf[1])
         FC_READ:
         begin
            // see R13
            if (req_count == '0 || req_count > 16'(MAX_WORDS)
                || rx_len != 6'h08)
               next_err = ERR_COUNT;
            else if (req_end > 17'(REG_WORDS))
               next_err = ERR_REG;
            next_reply_len = 6'h03 + {req_count[4:0], 1'b0};
         end
         FC_LOOP:
            next_reply_len = rx_len - 6'h02; // see R14
         FC_WRITE:
         begin
            // see R15
            if (req_count == '0 || req_count > 16'(MAX_WORDS)
                || rx_buf[6] != {2'b00, req_count[4:0], 1'b0}
                || rx_len != 6'h09 + {req_count[4:0], 1'b0})
               next_err = ERR_COUNT;
            else if (req_end > 17'(REG_WORDS))
               next_err = ERR_REG;
            next_reply_len = 6'h06;
         end
         default:
            next_err = ERR_FUNC; // see R16
      endcase
      if (next_err != ERR_NONE)
         next_reply_len = 6'h03; // see R21
   end

   assign wr_go = (state == st_exec) && frame_ok && addr_hit
      && (rx_buf[1] == FC_WRITE) && (next_err == ERR_NONE);

   // Each link register loads its word from the request when in range
   for (genvar k = 0; k < REG_WORDS; k++)
   begin : g_reg
      logic [4:0] off; // Word position inside the request data
      assign off = 5'(k) - req_start[4:0];
      always_ff @(posedge clock or negedge resetn)
      begin
         if (!resetn)
            regs[k] <= 16'h0000;
         else if (wr_go && 5'(k) >= req_start[4:0]
                  && 16'(off) < req_count)
            // Broadcasts rely on the master sending only run and frequency
            regs[k] <= {rx_buf[6'h07 + {off, 1'b0}],
                        rx_buf[6'h08 + {off, 1'b0}]}; // see R15 see R11
      end
   end

   // Phase sequencing
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state <= st_recv;
      else
      begin
         unique case (state)
            st_recv:
               if (frame_end)
                  state <= st_exec;
            st_exec:
               // Broadcasts execute silently
               if (frame_ok && addr_hit && !is_bcast)
                  state <= st_wait; // see R12
               else
                  state <= st_recv;
            st_wait:
               if (wait_ms >= reply_wait_time)
                  state <= st_send; // see R6
            st_send:
               if (fifo_in_ready && tx_idx == reply_len - 6'h01)
                  state <= st_crc_lo;
            st_crc_lo:
               if (fifo_in_ready)
                  state <= st_crc_hi;
            st_crc_hi:
               if (fifo_in_ready)
                  state <= st_recv;
         endcase
      end
   end

   // Reply facts latched at execute, and error and drop pulses
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         err_code <= ERR_NONE;
         reply_len <= '0;
         comm_error <= 1'b0;
         frame_dropped <= 1'b0;
      end
      else
      begin
         comm_error <= (state == st_exec) && frame_ok && addr_hit
            && (next_err != ERR_NONE); // see R16
         frame_dropped <= (state == st_exec) && !frame_ok; // see R22
         if (state == st_exec)
         begin
            err_code <= next_err;
            reply_len <= next_reply_len;
         end
      end
   end

   // Millisecond enable restarts at execute so the wait is whole
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         ms_cnt <= '0;
      else if (state == st_exec || ms_tick)
         ms_cnt <= '0;
      else
         ms_cnt <= ms_cnt + 16'h0001;
   end
   assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));

   // Programmed wait on top of the 24 idle bits already seen
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         wait_ms <= '0;
      else if (state == st_exec)
         wait_ms <= '0;
      else if (state == st_wait && ms_tick && wait_ms != 8'hff)
         wait_ms <= wait_ms + 8'h01; // see R6
   end

   // Reply byte: error form, read form, or copy of the request
   always_comb
   begin
      logic [4:0] widx;
      widx = req_start[4:0] + 5'((tx_idx - 6'h03) >> 1);
      reply_byte = rx_buf[tx_idx];
      if (err_code != ERR_NONE)
      begin
         if (tx_idx == 6'h01)
            reply_byte = rx_buf[1] | FC_ERR_BIT; // see R17
         else if (tx_idx == 6'h02)
            reply_byte = err_code; // see R21
      end
      else if (rx_buf[1] == FC_READ && tx_idx >= 6'h02)
      begin
         if (tx_idx == 6'h02)
            reply_byte = {2'b00, req_count[4:0], 1'b0};
         else if (tx_idx[0])
            reply_byte = regs[widx[3:0]][15:8]; // see R13
         else
            reply_byte = regs[widx[3:0]][7:0];
      end
   end

   // Queue feed: body bytes, then check word low byte first
   always_comb
   begin
      fifo_in_valid = (state == st_send) || (state == st_crc_lo)
         || (state == st_crc_hi);
      fifo_in_data = reply_byte; // see R20
      if (state == st_crc_lo)
         fifo_in_data = tx_crc[7:0]; // see R19
      else if (state == st_crc_hi)
         fifo_in_data = tx_crc[15:8];
   end

   // Reply index and check; a full queue simply holds the sequence
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_idx <= '0;
         tx_crc <= CRC_INIT;
      end
      else if (state == st_exec)
      begin
         tx_idx <= '0;
         tx_crc <= CRC_INIT;
      end
      else if (state == st_send && fifo_in_ready)
      begin
         tx_idx <= tx_idx + 6'h01;
         tx_crc <= crc16_step(tx_crc, reply_byte); // see R18
      end
   end

   // Reply queue between the handler and the line transmitter
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_reply_fifo (
      .clock(clock),
      .resetn(resetn),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(tx_valid),
      .out_data(tx_data),
      .out_ready(tx_ready)
   );

   // Blink timer for the operator display
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         blink_ms <= '0;
         blink_phase <= 1'b0;
      end
      else if (ms_tick)
      begin
         if (blink_ms == 8'(BLINK_MS - 1))
         begin
            blink_ms <= '0;
            blink_phase <= ~blink_phase;
         end
         else
            blink_ms <= blink_ms + 8'h01;
      end
   end

   // Command source choice and terminal-driven indications
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         run_command <= 16'h0000;
         freq_reference <= 16'h0000;
         overheat_prealarm <= 1'b0;
         ramp_time_select <= 2'b00;
      end
      else
      begin
         if (terminal_on(FUNC_COMM_SEL, input_terminals,
                         input_terminal_function_selects))
         begin
            run_command <= regs[REG_RUN]; // see R1
            freq_reference <= regs[REG_FREQ];
         end
         else
         begin
            run_command <= (run_source_select == RUN_SRC_COMM)
               ? regs[REG_RUN] : local_run_cmd; // see R2
            freq_reference <= (freq_ref_source_select == FREQ_SRC_COMM)
               ? regs[REG_FREQ] : local_freq_ref;
         end
         overheat_prealarm <= blink_phase && terminal_on(FUNC_PREALARM,
            input_terminals, input_terminal_function_selects); // see R3
         ramp_time_select <= {
            terminal_on(FUNC_RAMP2, input_terminals,
                        input_terminal_function_selects),
            terminal_on(FUNC_RAMP1, input_terminals,
                        input_terminal_function_selects)}; // see R4
      end
   end

   // Own quiet count, so the idle check does not reuse the divider
   logic [15:0] quiet;
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         quiet <= '0;
      else
         quiet <= (rx_valid && rx_ready) ? '0 : quiet + 16'h0001;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_bcast_no_reply : assert property ( // see R12
      (state == st_exec && is_bcast) |=> state == st_recv [*2])
      else $error("reply started for a broadcast");
   a_addr_filter : assert property ( // see R9
      (state == st_exec && !addr_hit) |=> state == st_recv)
      else $error("foreign address accepted");
   a_frame_idle_end : assert property ( // see R22
      frame_end |-> quiet == 16'(IDLE_BITS * BIT_CYCLES - 1))
      else $error("frame closed before 24 quiet bits");
   a_bad_check_drop : assert property ( // see R18
      (state == st_exec && rx_crc != 16'h0000) |=> frame_dropped
         && state == st_recv)
      else $error("frame with bad check not dropped");
   a_err_top_bit : assert property ( // see R17
      (state == st_send && tx_idx == 6'h01 && err_code != ERR_NONE)
         |-> fifo_in_data == (rx_buf[1] | 8'h80))
      else $error("error reply lacks top bit");
   a_unknown_code : assert property ( // see R16
      (state == st_exec && frame_ok && addr_hit && rx_buf[1] != FC_READ
         && rx_buf[1] != FC_LOOP && rx_buf[1] != FC_WRITE)
         |=> comm_error ##1 !comm_error)
      else $error("unknown code not flagged");
   a_check_low_first : assert property ( // see R19
      (state == st_crc_lo && fifo_in_ready) |=> state == st_crc_hi
         && $past(fifo_in_data) == $past(tx_crc[7:0]))
      else $error("check word sent high byte first");
   a_reply_wait : assert property ( // see R6
      (state == st_wait && wait_ms < reply_wait_time) |=> state == st_wait)
      else $error("reply started before wait time");
   a_link_select : assert property ( // see R1
      (terminal_on(FUNC_COMM_SEL, input_terminals,
         input_terminal_function_selects)) |=> run_command == $past(regs[1]))
      else $error("link run command not selected");

   c_read_reply : cover property (
      state == st_exec && frame_ok && addr_hit && rx_buf[1] == FC_READ);
   c_bcast_write : cover property (wr_go && is_bcast);
   c_error_reply : cover property (state == st_crc_hi && err_code != ERR_NONE);
   c_loop_back : cover property (
      state == st_crc_hi && rx_buf[1] == FC_LOOP);
endmodule : serial_slave_message_handler

/* File: master_model.sv */
`timescale 1ns/100ps
// Remote master on the line: sends whole request frames, takes replies
module master_model
   import msg_handler_pkg::*;
#(
   parameter int MS = 20
) (
   // Clock
   input wire logic clock,
   // Request bytes toward the handler
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   // Reply side
   input wire logic tx_valid,
   output logic tx_ready
);
   int hold = 0; // Turnaround cycles left
   // Idle line at reset
   initial
   begin
      rx_valid = 1'b0;
      rx_data = 8'h5a;
      tx_ready = 1'b0;
   end

   // Slow taker, so the reply queue is stalled every other cycle
   always @(negedge clock)
   begin
      tx_ready <= ~tx_ready;
   end

   // A taken reply byte restarts the turnaround wait
   always @(posedge clock)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         hold <= 24 * BIT_CYCLES + 10 * MS;
      else
         hold <= hold - 1;
   end

   // Raw bytes, one whole byte per handshake
   task automatic send(input logic [7:0] bytes[$]);
      while (hold > 0) @(negedge clock);
      foreach (bytes[i])
      begin
         @(negedge clock);
         rx_valid = 1'b1;
         rx_data = bytes[i];
         do @(posedge clock); while (rx_ready !== 1'b1);
      end
      @(negedge clock);
      rx_valid = 1'b0;
      // Released data must not keep looking like the last byte
      rx_data = ~rx_data;
   endtask : send
endmodule : master_model

/* File: serial_slave_message_handler_tb.sv */
`timescale 1ns/100ps
module serial_slave_message_handler_tb
   import msg_handler_pkg::*;
;
   localparam int MS = 20;
   // Clock, reset and bench state
   logic clock = 1'b0;
   logic resetn = 1'b0;
   int errors = 0;
   int comparisons = 0;
   int seed = 88;
   int cyc = 0;
   int sent_at = 0;
   logic [7:0] exp_q[$];
   logic [7:0] frame[$];
   logic [15:0] v, lrun, lfreq, run_cmd, freq_ref;
   logic [1:0] blink = 2'b00;
   // Design ports
   logic rx_valid, rx_ready, tx_valid, tx_ready, prealarm, c_err, drop;
   logic [7:0] rx_data, tx_data;
   logic [6:0] terms = 7'h00;
   logic [1:0] ramp;

   serial_slave_message_handler #(.MS_CYCLES(MS))
      u_serial_slave_message_handler (
      .clock(clock), .resetn(resetn),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .link_station_number(8'h02), .reply_wait_time(8'h02),
      .run_source_select(2'h0), .freq_ref_source_select(4'h0),
      .input_terminals(terms),
      .input_terminal_function_selects(
         {18'h00000, FUNC_PREALARM, FUNC_RAMP2, FUNC_RAMP1, FUNC_COMM_SEL}),
      .local_run_cmd(lrun), .local_freq_ref(lfreq),
      .run_command(run_cmd), .freq_reference(freq_ref),
      .overheat_prealarm(prealarm), .ramp_time_select(ramp),
      .comm_error(c_err), .frame_dropped(drop));

   master_model #(.MS(MS)) u_master (.clock(clock), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_ready(tx_ready));

   // Free-running clock and cycle count
   initial
   begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
   end

   task automatic check(input string what, input logic [15:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   // Own check word, reflected form of the generator, from all ones
   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ (c[0] ? 16'ha001 : 16'h0000);
      end
      return c;
   endfunction : crc

   // Appends the check word low byte first
   task automatic add_crc(inout logic [7:0] q[$]);
      logic [15:0] c;
      c = crc(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask : add_crc

   // Reply watcher: every byte taken must match the oldest note
   always @(posedge clock)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected reply", 16'h0000, 16'h0001);
         else
         begin
            if (sent_at != 0)
               check("reply gap", 16'h0001,
                  16'(cyc - sent_at >= 24 * BIT_CYCLES + 2 * MS));
            sent_at = 0;
            check("reply", {8'h00, exp_q.pop_front()},
               {8'h00, tx_data});
         end
      end
      if (resetn && {c_err, drop} !== 2'b00)
         check("error pulses", 16'h0000, {14'h0, c_err, drop});
   end

   // Watchdog: the two frames need about 100300 cycles
   initial
   begin
      repeat (101000) @(posedge clock);
      errors++;
      $display("MISMATCH watchdog expired");
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      lrun = 16'($random(seed));
      lfreq = 16'($random(seed));
      v = 16'($random(seed));
      repeat (6) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      // Local sources while the link selector terminal is off
      repeat (4)
      begin
         @(negedge clock);
         terms = {4'h0, 2'($random(seed)), 1'b0};
         repeat (2) @(negedge clock);
         check("run local", lrun, run_cmd);
         check("freq local", lfreq, freq_ref);
         check("ramp", {14'h0, terms[2:1]}, {14'h0, ramp});
      end
      // Broadcast write of the run register, must stay silent
      frame = '{8'h00, FC_WRITE, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02,
         v[15:8], v[7:0]};
      add_crc(frame);
      u_master.send(frame);
      // Pre-alarm terminal on: display blinks
      terms[3] = 1'b1;
      repeat (24 * BIT_CYCLES + 10)
      begin
         @(negedge clock);
         blink = blink | (prealarm === 1'b1 ? 2'b10 : 2'b01);
      end
      check("prealarm blink", 16'h0003, {14'h0, blink});
      terms[3] = 1'b0;
      // Addressed read of the same register
      exp_q = '{8'h02, FC_READ, 8'h02, v[15:8], v[7:0]};
      add_crc(exp_q);
      frame = '{8'h02, FC_READ, 8'h00, 8'h01, 8'h00, 8'h01};
      add_crc(frame);
      u_master.send(frame);
      sent_at = cyc;
      repeat (24 * BIT_CYCLES + 2 * MS + 200) @(negedge clock);
      check("reply left", 16'h0000, 16'(exp_q.size()));
      // Selector terminal on: run command now comes from the link
      terms[0] = 1'b1;
      repeat (2) @(negedge clock);
      check("run link", v, run_cmd);
      check("freq link", 16'h0000, freq_ref);
      check("prealarm off", 16'h0000, {15'h0, prealarm});
      tally_and_finish();
   end
endmodule : serial_slave_message_handler_tb
